// >>> dv/secp_host.sv
// Host model that drives the serial link of the EEPROM command port
`timescale 1ns/1ns
module secp_host (
	input wire logic clock,
	output logic chip_select,
	output logic serial_clock,
	output logic serial_in,
	input wire logic serial_out,
	input wire logic serial_out_oen
);
	// Floating data line reads as the inverse, so stale data never passes
	logic line;
	assign line = serial_out_oen ? ~serial_out : serial_out;

	initial begin
		chip_select = 1'b0;
		serial_clock = 1'b0;
		serial_in = 1'b0;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clock);
	endtask : wait_clk

	// select low over 1 us before each frame
	// start marker and every bit, MSB first, 800 ns per bit
	task automatic frame(input int n, input logic [31:0] v,
		output logic [31:0] got);
		got = '0;
		wait_clk(12);
		chip_select <= 1'b1;
		for (int i = n - 1; i >= 0; i--) begin
			@(posedge clock);
			serial_clock <= 1'b0;
			serial_in <= v[i];
			wait_clk(2);
			if (i < n - 1) got = {got[30:0], line};
			wait_clk(2);
			serial_clock <= 1'b1;
			wait_clk(3);
		end
		@(posedge clock);
		serial_clock <= 1'b0;
		// Released data line toggles so a stale level is never trusted
		serial_in <= ~serial_in;
		wait_clk(2);
		got = {got[30:0], line};
		// select drops before any further rise
		@(posedge clock);
		chip_select <= 1'b0;
	endtask : frame

	// select raised after 300 ns, poll busy then ready
	task automatic status(output logic busy, output logic rdy);
		int n;
		wait_clk(3);
		chip_select <= 1'b1;
		wait_clk(6);
		busy = line;
		n = 0;
		while (line !== 1'b1 && n < 200) begin
			wait_clk(1);
			n++;
		end
		rdy = line;
		chip_select <= 1'b0;
	endtask : status
endmodule : secp_host

// >>> dv/serial_eeprom_command_port_tb_top.sv
// Self-checking bench for the serial EEPROM command port
`timescale 1ns/1ns
`include "secp_cfg.svh"
module serial_eeprom_command_port_tb_top;
	localparam int AW = 6;
	logic clock, rstn, chip_select, serial_clock, serial_in;
	logic serial_out, serial_out_oen, busy, rdy;
	int failures = 0;
	int n_checks = 0;
	logic [15:0] mem [64];
	logic [31:0] got;
	logic [AW-1:0] a;
	logic [15:0] d;

	secp_eeprom #(.ADDR_BITS(AW), .ADDR_USED(AW), .PROG_CYCLES(20))
	secp_eeprom_i (.clock(clock), .rstn(rstn), .chip_select(chip_select),
		.serial_clock(serial_clock), .serial_in(serial_in),
		.serial_out(serial_out), .serial_out_oen(serial_out_oen));
	secp_host secp_host_i (.clock(clock), .chip_select(chip_select),
		.serial_clock(serial_clock), .serial_in(serial_in),
		.serial_out(serial_out), .serial_out_oen(serial_out_oen));

	initial begin
		clock = 1'b0;
		rstn = 1'b0;
		forever #50 clock = ~clock;
	end

	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] seen);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic summarize();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : summarize

	function automatic logic [15:0] rnd_word();
		return 16'($urandom);
	endfunction : rnd_word

	task automatic rd(input logic [AW-1:0] ra);
		secp_host_i.frame(25, {7'h0, 1'b1, `SECP_OP_READ, ra, 16'h0}, got);
		check("read", {15'h0, 1'b0, mem[ra]}, {15'h0, got[16:0]});
		secp_host_i.wait_clk(5);
		check("oen", 32'h1, {31'h0, serial_out_oen});
	endtask : rd

	task automatic prog(input logic [1:0] op, input logic [AW-1:0] pa,
		input logic [15:0] pd, input bit wd, input bit en);
		if (wd) secp_host_i.frame(25, {7'h0, 1'b1, op, pa, pd}, got);
		else secp_host_i.frame(9, {23'h0, 1'b1, op, pa}, got);
		if (en) begin
			secp_host_i.status(busy, rdy);
			check("busy", 32'h0, {31'h0, busy});
			check("ready", 32'h1, {31'h0, rdy});
		end
	endtask : prog

	initial begin
		void'($urandom(32'h5404cf0a));
		foreach (mem[i]) mem[i] = 16'h0;
		repeat (3) @(posedge clock);
		rstn <= 1'b1;
		secp_host_i.wait_clk(3);
		check("oen idle", 32'h1, {31'h0, serial_out_oen});
		a = AW'($urandom);
		prog(`SECP_OP_WRITE, a, rnd_word(), 1, 0);
		rd(a);
		$display("test disabled write done");
		prog(`SECP_OP_SPECIAL, {`SECP_SP_ENABLE, 4'($urandom)}, 0, 0, 0);
		for (int i = 0; i < 4; i++) begin
			a = (i == 0) ? '1 : AW'($urandom);
			d = (i == 1) ? 16'h8001 : rnd_word();
			mem[a] = d;
			prog(`SECP_OP_WRITE, a, d, 1, 1);
			rd(a);
		end
		prog(`SECP_OP_ERASE, a, 0, 0, 1);
		mem[a] = 16'hffff;
		rd(a);
		$display("test write and erase done");
		d = rnd_word();
		prog(`SECP_OP_SPECIAL, {`SECP_SP_WRITE_ALL, 4'($urandom)}, d, 1, 1);
		foreach (mem[i]) mem[i] = d;
		rd(6'h0);
		rd(AW'($urandom));
		prog(`SECP_OP_SPECIAL, {`SECP_SP_ERASE_ALL, 4'($urandom)}, 0, 0, 1);
		foreach (mem[i]) mem[i] = 16'hffff;
		rd(6'h3f);
		$display("test bulk done");
		a = AW'($urandom);
		secp_host_i.frame(12, {20'h0, 1'b1, `SECP_OP_WRITE, a, 3'h0}, got);
		rd(a);
		secp_host_i.frame(26, {6'h0, 1'b1, `SECP_OP_WRITE, a, 17'h0}, got);
		rd(a);
		$display("test abort done");
		// Neighbour holds a non-erased word so a locked erase would show
		mem[a ^ 6'h1] = 16'h5a5a;
		prog(`SECP_OP_WRITE, a ^ 6'h1, 16'h5a5a, 1, 1);
		prog(`SECP_OP_SPECIAL, {`SECP_SP_DISABLE, 4'($urandom)}, 0, 0, 0);
		prog(`SECP_OP_WRITE, a, 16'h1234, 1, 0);
		prog(`SECP_OP_ERASE, a ^ 6'h1, 0, 0, 0);
		rd(a);
		rd(a ^ 6'h1);
		$display("test disable done");
		summarize();
	end

	// Bound is several times the expected run length
	initial begin
		repeat (60000) @(posedge clock);
		failures++;
		summarize();
	end
endmodule : serial_eeprom_command_port_tb_top

// >>> rtl/secp_cfg.svh
// Constants of the serial EEPROM command port
`ifndef SECP_CFG_SVH
`define SECP_CFG_SVH
// Core clock period and self-timed programming time
`define SECP_CLK_NS 100
`define SECP_T_WP_NS 10000000
// Opcodes that follow the start marker
`define SECP_OP_SPECIAL 2'h0
`define SECP_OP_WRITE 2'h1
`define SECP_OP_READ 2'h2
`define SECP_OP_ERASE 2'h3
// Special commands, top two address bits under the special opcode
`define SECP_SP_DISABLE 2'h0
`define SECP_SP_WRITE_ALL 2'h1
`define SECP_SP_ERASE_ALL 2'h2
`define SECP_SP_ENABLE 2'h3
// Reset value of the enable latch and level of an erased bit
`define SECP_WEN_RST 1'h0
`define SECP_ERASED_BIT 1'h1
`endif

// >>> rtl/secp_eeprom.sv
// Serial EEPROM command port: framing, decode, programming and storage
`timescale 1ns/1ns
`include "secp_cfg.svh"
// Behaviour
// - Instruction starts with start marker one
// - Small variant: opcode plus 6-bit address
// - Large variant: opcode plus 8-bit address
// - Read sends dummy zero then 16 bits
// - Read output changes only on serial_clock rise; status follows busy
// - Power-up leaves programming disabled
// - Enable holds until disable or reset
// - Erase sets addressed word to ones
// - Chip select fall starts erase cycle
// - Output shows busy zero, ready one
// - Write takes 16 data bits, MSB first
// - Status shown when select raised again
// - Erase all sets every word ones
// - Write all programs every word
// - Disable blocks programming; reads work unless a job is pending or the queue is full
// - Decode 10 read, 01 write, 11 erase
// - Special 11 enable, 10 erase all, 01 write all
// - Special 00 is programming disable
// - Unused upper address bits are ignored
module secp_eeprom
	import secp_pkg::*;
#(
	parameter int ADDR_BITS = 6,
	parameter int ADDR_USED = 6,
	parameter int WORD_BITS = 16,
	parameter int FIFO_DEPTH = 2,
	parameter int PROG_CYCLES = `SECP_T_WP_NS / `SECP_CLK_NS
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic chip_select,
	input wire logic serial_clock,
	input wire logic serial_in,
	output logic serial_out,
	output logic serial_out_oen
);

	// ****************************************************************
	// Sizes and state
	// ****************************************************************
	localparam int FRAME = 2 + ADDR_BITS;
	localparam int WORDS = 1 << ADDR_USED;
	localparam int CW = $clog2(FRAME + WORD_BITS + 1);
	localparam int TW = $clog2(PROG_CYCLES + 1);
	localparam int EW = 1 + ADDR_BITS + WORD_BITS;
	localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
	localparam int QW = $clog2(FIFO_DEPTH + 1);

	typedef struct packed {
		logic cs_m;
		logic cs_s;
		logic sk_m;
		logic sk_s;
		logic sk_d;
		logic di_m;
		logic di_s;
		secp_st_t st;
		logic [CW-1:0] cnt;
		logic [FRAME-1:0] cmd;
		logic [WORD_BITS-1:0] sh;
		logic wen;
		logic pend;
		logic show;
		logic [EW-1:0] job;
		logic dout;
		logic drv;
		logic [FIFO_DEPTH-1:0][EW-1:0] fq;
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [QW-1:0] qn;
		logic eng;
		logic [TW-1:0] tmr;
		logic [EW-1:0] cur;
		logic [WORDS-1:0][WORD_BITS-1:0] mem;
	} secp_core_t;

	secp_core_t s;
	secp_core_t next_s;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [EW-1:0] pack_job(
		input logic all,
		input logic [ADDR_BITS-1:0] a,
		input logic [WORD_BITS-1:0] d
	);
		pack_job = {all, a, d};
	endfunction : pack_job

	function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
		if (p == PW'(FIFO_DEPTH - 1)) begin
			ptr_inc = '0;
		end else begin
			ptr_inc = p + 1'b1;
		end
	endfunction : ptr_inc

	logic sk_rise;
	logic [FRAME-1:0] full;
	logic [1:0] op;
	logic [1:0] top;
	logic [ADDR_BITS-1:0] addr;
	logic last_bit;
	logic q_in_ready;
	logic q_out_valid;
	logic push;
	logic pop;
	logic busy;
	logic commit;
	logic cur_all;
	logic [ADDR_USED-1:0] cur_idx;
	logic [WORD_BITS-1:0] cur_data;

	assign sk_rise = s.sk_s & ~s.sk_d;
	assign full = {s.cmd[FRAME-2:0], s.di_s};
	assign op = full[FRAME-1:FRAME-2];
	assign top = full[ADDR_BITS-1:ADDR_BITS-2];
	assign addr = full[ADDR_BITS-1:0];
	assign last_bit = (s.st == ST_CMD) && sk_rise
		&& (s.cnt == CW'(FRAME - 1));

	// Two-entry queue between the decoder and the programming engine
	assign q_in_ready = s.qn != QW'(FIFO_DEPTH);
	assign q_out_valid = s.qn != '0;
	assign push = s.pend && q_in_ready;
	assign pop = q_out_valid && !s.eng;
	assign busy = s.pend || q_out_valid || s.eng;
	assign commit = s.eng && (s.tmr == '0);
	assign cur_all = s.cur[EW-1];
	assign cur_idx = s.cur[WORD_BITS +: ADDR_USED];
	assign cur_data = s.cur[WORD_BITS-1:0];

	assign serial_out = s.dout;
	assign serial_out_oen = ~s.drv;

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		next_s = s;
		next_s.cs_m = chip_select;
		next_s.cs_s = s.cs_m;
		next_s.sk_m = serial_clock;
		next_s.sk_s = s.sk_m;
		next_s.sk_d = s.sk_s;
		next_s.di_m = serial_in;
		next_s.di_s = s.di_m;

		if (push) begin
			next_s.fq[s.wp] = s.job;
			next_s.wp = ptr_inc(s.wp);
			next_s.pend = 1'b0;
		end
		if (pop) begin
			next_s.cur = s.fq[s.rp];
			next_s.rp = ptr_inc(s.rp);
			next_s.eng = 1'b1;
			next_s.tmr = TW'(PROG_CYCLES - 1);
		end
		next_s.qn = QW'(s.qn + QW'(push) - QW'(pop));

		if (s.eng) begin
			if (commit) begin
				next_s.eng = 1'b0;
				if (cur_all) begin
					for (int i = 0; i < WORDS; i++) begin
						next_s.mem[i] = cur_data;
					end
				end else begin
					next_s.mem[cur_idx] = cur_data;
				end
			end else begin
				next_s.tmr = s.tmr - 1'b1;
			end
		end

		if (!s.cs_s) begin
			next_s.st = ST_IDLE;
			next_s.cnt = '0;
			next_s.drv = 1'b0;
			if (s.st == ST_PROG) begin
				next_s.pend = 1'b1;
				next_s.show = 1'b1;
			end
		end else begin
			case (s.st)
			ST_IDLE: begin
				if (s.show) begin
					next_s.drv = 1'b1;
					next_s.dout = ~busy;
				end
				if (sk_rise && s.di_s && !s.pend && q_in_ready) begin
					next_s.st = ST_CMD;
					next_s.cnt = '0;
					next_s.show = 1'b0;
					next_s.drv = 1'b0;
				end
			end
			ST_CMD: begin
				if (sk_rise) begin
					next_s.cmd = full;
					next_s.cnt = s.cnt + 1'b1;
				end
				if (last_bit) begin
					next_s.cnt = '0;
					next_s.st = ST_DONE;
					case (op)
					`SECP_OP_READ: begin
						next_s.st = ST_READ;
						next_s.sh = s.mem[addr[ADDR_USED-1:0]];
						next_s.drv = 1'b1;
						next_s.dout = 1'b0;
					end
					`SECP_OP_WRITE: begin
						if (s.wen) begin
							next_s.st = ST_WDATA;
							next_s.job = pack_job(1'b0, addr, '0);
						end
					end
					`SECP_OP_ERASE: begin
						if (s.wen) begin
							next_s.st = ST_PROG;
							next_s.job = pack_job(1'b0, addr,
								{WORD_BITS{`SECP_ERASED_BIT}});
						end
					end
					default: begin
						case (top)
						`SECP_SP_ENABLE: next_s.wen = 1'b1;
						`SECP_SP_DISABLE: next_s.wen = 1'b0;
						`SECP_SP_ERASE_ALL: begin
							if (s.wen) begin
								next_s.st = ST_PROG;
								next_s.job = pack_job(1'b1, addr,
									{WORD_BITS{`SECP_ERASED_BIT}});
							end
						end
						default: begin
							if (s.wen) begin
								next_s.st = ST_WDATA;
								next_s.job = pack_job(1'b1, addr, '0);
							end
						end
						endcase
					end
					endcase
				end
			end
			ST_READ: begin
				if (sk_rise) begin
					next_s.dout = s.sh[WORD_BITS-1];
					next_s.sh = s.sh << 1;
					next_s.cnt = s.cnt + 1'b1;
					if (s.cnt == CW'(WORD_BITS - 1)) begin
						next_s.st = ST_DONE;
					end
				end
			end
			ST_WDATA: begin
				if (sk_rise) begin
					next_s.job[WORD_BITS-1:0] =
						{s.job[WORD_BITS-2:0], s.di_s};
					next_s.cnt = s.cnt + 1'b1;
					if (s.cnt == CW'(WORD_BITS - 1)) begin
						next_s.st = ST_PROG;
					end
				end
			end
			ST_PROG: begin
				if (sk_rise) begin
					next_s.st = ST_DONE;
				end
			end
			ST_DONE: begin
			end
			default: next_s.st = ST_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	// enable latch clears only at reset or disable
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	out_on_rise_a: assert property (
		(s.st == ST_READ && $past(s.st) == ST_READ && s.cs_s
			&& $changed(s.dout)) |-> $past(sk_rise)
	) else $error("read data changed without a clock rise");

	float_cs_low_a: assert property (
		!s.cs_s |=> !s.drv ##1 !s.drv || s.cs_s
	) else $error("output driven while select low");

	dummy_zero_a: assert property (
		(last_bit && op == `SECP_OP_READ && s.cs_s)
			|=> s.drv && !s.dout && s.st == ST_READ
	) else $error("read did not start with a dummy zero");

	enable_set_a: assert property (
		(last_bit && s.cs_s && op == `SECP_OP_SPECIAL
			&& top == `SECP_SP_ENABLE) |=> s.wen
	) else $error("enable command not taken");

	disable_clr_a: assert property (
		(last_bit && s.cs_s && op == `SECP_OP_SPECIAL
			&& top == `SECP_SP_DISABLE) |=> !s.wen [*2]
	) else $error("disable command not taken");

	locked_push_a: assert property (
		(s.st == ST_CMD && !s.wen && last_bit) |=> s.st != ST_PROG
			&& s.st != ST_WDATA
	) else $error("programming accepted while disabled");

	word_commit_a: assert property (
		(commit && !cur_all)
			|=> s.mem[$past(cur_idx)] == $past(cur_data)
	) else $error("programmed word not stored");

	all_commit_a: assert property (
		(commit && cur_all) |=> s.mem[0] == $past(cur_data)
			&& s.mem[WORDS-1] == $past(cur_data)
	) else $error("bulk program missed words");

	busy_low_a: assert property (
		(s.eng && s.cs_s && s.show && s.st == ST_IDLE
			&& $past(s.eng)) |=> !s.dout
	) else $error("status showed ready while programming");

endmodule : secp_eeprom

// >>> rtl/secp_pkg.sv
// Types of the serial EEPROM command port
package secp_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CMD,
		ST_READ,
		ST_WDATA,
		ST_PROG,
		ST_DONE
	} secp_st_t;
endpackage : secp_pkg
